/* logic/slcs_pkg.sv */
// constants and carrier structs for strap latch and clock select
package slcs_pkg;

   // ===================================================
   // timing
   localparam int unsigned CLK_MHZ = 125;
   localparam int unsigned RESET_PULSE_MS = 250;
   localparam int unsigned RESET_PULSE_CYC = RESET_PULSE_MS * CLK_MHZ * 1000;
   localparam int unsigned POR_HOLD_CYC = 16;

   // ===================================================
   // register 16 bit positions and strap defaults
   localparam int unsigned CFG16_IO_RATE_BIT = 7;
   localparam int unsigned CFG16_MID_RATE_BIT = 6;
   localparam logic MID_RATE_DEFAULT = 1'b1;
   localparam logic IO_RATE_DEFAULT = 1'b0;
   localparam logic [4:0] FREQ_SEL_DEFAULT = 5'h1f;
   localparam logic [1:0] DRIVE_DEFAULT = 2'h3;

   // ===================================================
   // carriers
   typedef struct packed {
      logic [4:0] freq_select_straps;
      logic mid_rate_choice_strap;
      logic io_clock_rate_strap;
      logic drive_current_strap_hi;
      logic drive_current_strap_lo;
   } slcs_straps_s;

   typedef struct packed {
      logic sw_freq_enable;
      logic [4:0] sw_freq_select;
      logic safe_freq_reload_enable;
      logic [4:0] safe_freq_select;
      logic cfg16_wr;
      logic [7:0] cfg16_wdata;
   } slcs_host_cfg_s;

   typedef enum logic [1:0] {
      ST_WAIT_PG = 2'b00,
      ST_SETTLE = 2'b01,
      ST_RUN = 2'b11
   } slcs_state_e;

endpackage : slcs_pkg

/* logic/slcs_sync.sv */
// two flop synchroniser for a vector of levels
`timescale 1ns/10ps
module slcs_sync #(
   parameter int unsigned WIDTH = 1,
   parameter logic [WIDTH-1:0] INIT = '0
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic [WIDTH-1:0] d_i,
   output logic [WIDTH-1:0] q_o
);
   logic [WIDTH-1:0] meta_r;
   logic [WIDTH-1:0] sync_r;

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         meta_r <= INIT;
         sync_r <= INIT;
      end else begin
         meta_r <= d_i;
         sync_r <= meta_r;
      end
   end

   assign q_o = sync_r;
endmodule : slcs_sync

/* logic/slcs_top.sv */
// strap latch and clock select logic of a clock synthesizer
`timescale 1ns/10ps
module slcs_top
   import slcs_pkg::*;
#(
   parameter int unsigned RESET_PULSE_CYCLES = RESET_PULSE_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   // ===================================================
   // link side: host register port on its own clock
   input wire logic host_clk_i,
   input wire logic host_reset_i,
   input wire slcs_host_cfg_s host_cfg_i,
   output logic [7:0] cfg16_rdata_o,
   // ===================================================
   // pins
   input wire slcs_straps_s straps_i,
   input wire logic power_good_strobe_n_i,
   input wire logic power_down_in_n_i,
   input wire logic watchdog_timeout_i,
   input wire logic [5:0] pci_stop_i,
   output logic straps_as_outputs_o,
   output logic [4:0] freq_code_o,
   output logic [1:0] drive_current_mode_o,
   output logic shared_out_is_48m_o,
   output logic super_io_clock_is_48m_o,
   output logic usb_48m_enable_o,
   output logic [2:0] free_running_pci_enable_o,
   output logic [5:0] pci_enable_o,
   output logic power_down_o,
   output logic sys_reset_n_o,
   output logic sys_reset_oe_o
);

   // ===================================================
   // input synchronisers
   slcs_straps_s straps_s;
   logic pg_n_s;
   logic pd_n_s;
   logic wdt_s;
   logic [5:0] stop_s;

   // one synchroniser per pin group so every init value matches the
   // idle level of its pin and no false edge follows reset
   slcs_sync #(
      .WIDTH(9),
      .INIT({FREQ_SEL_DEFAULT, MID_RATE_DEFAULT, IO_RATE_DEFAULT,
             DRIVE_DEFAULT})
   ) u_strap_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(straps_i),
      .q_o(straps_s)
   );

   slcs_sync #(
      .WIDTH(1),
      .INIT(1'b1)
   ) u_pg_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(power_good_strobe_n_i),
      .q_o(pg_n_s)
   );

   slcs_sync #(
      .WIDTH(1),
      .INIT(1'b1)
   ) u_pd_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(power_down_in_n_i),
      .q_o(pd_n_s)
   );

   slcs_sync #(
      .WIDTH(1),
      .INIT(1'b0)
   ) u_wdt_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(watchdog_timeout_i),
      .q_o(wdt_s)
   );

   // stop bits are independent levels, so a per-bit sync is enough
   slcs_sync #(
      .WIDTH(6),
      .INIT(6'h00)
   ) u_stop_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i(pci_stop_i),
      .q_o(stop_s)
   );

   // ===================================================
   // host domain: register 16 write toggles
   typedef struct packed {
      logic [1:0] cfg16_bits;
      logic wr_pend;
      logic wr_tgl;
   } slcs_host_state_s;

   slcs_host_state_s h_r;
   slcs_host_state_s h_nxt;

   always_comb begin
      h_nxt = h_r;
      h_nxt.wr_pend = 1'b0;
      if (host_cfg_i.cfg16_wr) begin
         h_nxt.cfg16_bits = {host_cfg_i.cfg16_wdata[CFG16_IO_RATE_BIT],
                             host_cfg_i.cfg16_wdata[CFG16_MID_RATE_BIT]};
         h_nxt.wr_pend = 1'b1;
      end
      // toggle moves one host cycle after the data, so the core never
      // sees a fresh toggle beside data bits still settling
      if (h_r.wr_pend) begin
         h_nxt.wr_tgl = ~h_r.wr_tgl;
      end
   end

   always_ff @(posedge host_clk_i or posedge host_reset_i) begin
      if (host_reset_i) begin
         h_r <= '0;
      end else begin
         h_r <= h_nxt;
      end
   end

   // the data bits are held stable before the toggle moves, so the
   // core may sample them once the synchronised toggle differs
   logic [1:0] cfg_bits_s;
   logic wr_tgl_s;
   slcs_sync #(
      .WIDTH(3),
      .INIT(3'h0)
   ) u_cfg_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i({h_r.cfg16_bits, h_r.wr_tgl}),
      .q_o({cfg_bits_s, wr_tgl_s})
   );

   // bit 1 software frequency enable, bit 0 safe reload enable
   logic [1:0] host_misc_s;
   slcs_sync #(
      .WIDTH(2),
      .INIT(2'h0)
   ) u_sel_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i({host_cfg_i.sw_freq_enable, host_cfg_i.safe_freq_reload_enable}),
      .q_o(host_misc_s)
   );

   // freq fields are quasi-static words; sampled through the same
   // two flops and taken only when two samples agree
   logic [9:0] freq_fields_s;
   slcs_sync #(
      .WIDTH(10),
      .INIT(10'h000)
   ) u_freq_sync (
      .clk_i(clk_i),
      .reset_i(reset_i),
      .d_i({host_cfg_i.sw_freq_select, host_cfg_i.safe_freq_select}),
      .q_o(freq_fields_s)
   );

   // ===================================================
   // core state
   typedef struct packed {
      slcs_state_e state;
      logic [4:0] por_cnt;
      slcs_straps_s latched;
      logic mid_rate_sel;
      logic io_rate_sel;
      logic wr_tgl_seen;
      logic [9:0] freq_prev;
      logic [9:0] freq_ok;
      logic wdt_prev;
      logic wdt_override;
      logic [4:0] wdt_code;
      logic [31:0] pulse_cnt;
      logic reset_low;
      logic [4:0] freq_code;
      logic [2:0] out_flags;
      logic [5:0] pci_en;
   } slcs_core_s;

   slcs_core_s c_r;
   slcs_core_s c_nxt;

   always_comb begin
      c_nxt = c_r;
      c_nxt.freq_prev = freq_fields_s;
      if (freq_fields_s == c_r.freq_prev) begin
         c_nxt.freq_ok = freq_fields_s;
      end
      c_nxt.wdt_prev = wdt_s;
      unique case (c_r.state)
         ST_WAIT_PG: begin
            // power good low is the strobe that straps are valid
            if (!pg_n_s) begin
               c_nxt.latched = straps_s;
               c_nxt.mid_rate_sel = straps_s.mid_rate_choice_strap;
               c_nxt.io_rate_sel = straps_s.io_clock_rate_strap;
               c_nxt.por_cnt = 5'(POR_HOLD_CYC);
               c_nxt.state = ST_SETTLE;
            end
         end
         ST_SETTLE: begin
            // host writes are ignored inside the power-on reset period
            c_nxt.wr_tgl_seen = wr_tgl_s;
            if (c_r.por_cnt == 5'h00) begin
               c_nxt.state = ST_RUN;
            end else begin
               c_nxt.por_cnt = c_r.por_cnt - 5'h01;
            end
         end
         ST_RUN: begin
            if (wr_tgl_s != c_r.wr_tgl_seen) begin
               c_nxt.wr_tgl_seen = wr_tgl_s;
               c_nxt.mid_rate_sel = cfg_bits_s[0];
               c_nxt.io_rate_sel = cfg_bits_s[1];
            end
            if (wdt_s && !c_r.wdt_prev) begin
               c_nxt.wdt_override = 1'b1;
               c_nxt.wdt_code = host_misc_s[0]
                  ? c_r.freq_ok[4:0]
                  : c_r.latched.freq_select_straps;
               c_nxt.reset_low = 1'b1;
               c_nxt.pulse_cnt = 32'(RESET_PULSE_CYCLES - 1);
            end else if (c_r.reset_low) begin
               if (c_r.pulse_cnt == 32'h0) begin
                  c_nxt.reset_low = 1'b0;
               end else begin
                  c_nxt.pulse_cnt = c_r.pulse_cnt - 32'h1;
               end
            end
         end
         default: begin
            c_nxt.state = ST_WAIT_PG;
         end
      endcase
      // frequency selection; latched straps stay untouched after capture
      if (c_r.wdt_override) begin
         c_nxt.freq_code = c_r.wdt_code;
      end else if (host_misc_s[1]) begin
         c_nxt.freq_code = c_r.freq_ok[9:5];
      end else begin
         c_nxt.freq_code = c_r.latched.freq_select_straps;
      end
      // 0 selects 48 MHz on the shared pin, pull-up default is 66 MHz
      c_nxt.out_flags = {!c_r.mid_rate_sel, c_r.io_rate_sel, 1'b1};
      c_nxt.pci_en = ~stop_s;
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         c_r <= '{state: ST_WAIT_PG,
                  por_cnt: 5'h00,
                  latched: '{FREQ_SEL_DEFAULT, MID_RATE_DEFAULT,
                             IO_RATE_DEFAULT, DRIVE_DEFAULT[1],
                             DRIVE_DEFAULT[0]},
                  mid_rate_sel: MID_RATE_DEFAULT,
                  io_rate_sel: IO_RATE_DEFAULT,
                  wr_tgl_seen: 1'b0,
                  freq_prev: 10'h000,
                  freq_ok: 10'h000,
                  wdt_prev: 1'b0,
                  wdt_override: 1'b0,
                  wdt_code: 5'h00,
                  pulse_cnt: 32'h0,
                  reset_low: 1'b0,
                  freq_code: FREQ_SEL_DEFAULT,
                  out_flags: 3'h1,
                  pci_en: 6'h3f};
      end else begin
         c_r <= c_nxt;
      end
   end

   // ===================================================
   // host readback of register 16 from the core, in host domain
   logic [1:0] rb_s;
   slcs_sync #(
      .WIDTH(2),
      .INIT({IO_RATE_DEFAULT, MID_RATE_DEFAULT})
   ) u_rb_sync (
      .clk_i(host_clk_i),
      .reset_i(host_reset_i),
      .d_i({c_r.io_rate_sel, c_r.mid_rate_sel}),
      .q_o(rb_s)
   );

   always_comb begin
      cfg16_rdata_o = 8'h00;
      cfg16_rdata_o[CFG16_IO_RATE_BIT] = rb_s[1];
      cfg16_rdata_o[CFG16_MID_RATE_BIT] = rb_s[0];
   end

   // ===================================================
   // outputs
   assign straps_as_outputs_o = (c_r.state != ST_WAIT_PG);
   assign freq_code_o = c_r.freq_code;
   assign drive_current_mode_o = {c_r.latched.drive_current_strap_hi,
                                  c_r.latched.drive_current_strap_lo};
   assign shared_out_is_48m_o = c_r.out_flags[2];
   assign super_io_clock_is_48m_o = c_r.out_flags[1];
   assign usb_48m_enable_o = c_r.out_flags[0];
   // free-running group ignores pci_stop_i entirely
   assign free_running_pci_enable_o = 3'h7;
   assign pci_enable_o = c_r.pci_en;
   assign power_down_o = !pd_n_s;
   // open drain: only ever pulls low
   assign sys_reset_n_o = 1'b0;
   assign sys_reset_oe_o = c_r.reset_low;

endmodule : slcs_top

/* testbench/slcs_checker.sv */
// assertions on the strap latch and clock select ports
`timescale 1ns/10ps
module slcs_checker
   import slcs_pkg::*;
#(
   parameter int unsigned RESET_PULSE_CYCLES = RESET_PULSE_CYC
) (
   input wire logic clk_i,
   input wire logic reset_i,
   input wire logic host_clk_i,
   input wire logic host_reset_i,
   input wire slcs_host_cfg_s host_cfg_i,
   input wire logic [7:0] cfg16_rdata_o,
   input wire slcs_straps_s straps_i,
   input wire logic power_good_strobe_n_i,
   input wire logic power_down_in_n_i,
   input wire logic watchdog_timeout_i,
   input wire logic [5:0] pci_stop_i,
   input wire logic straps_as_outputs_o,
   input wire logic [4:0] freq_code_o,
   input wire logic [1:0] drive_current_mode_o,
   input wire logic shared_out_is_48m_o,
   input wire logic super_io_clock_is_48m_o,
   input wire logic usb_48m_enable_o,
   input wire logic [2:0] free_running_pci_enable_o,
   input wire logic [5:0] pci_enable_o,
   input wire logic power_down_o,
   input wire logic sys_reset_n_o,
   input wire logic sys_reset_oe_o
);
   // ====
   // pulse length counter, too long for a repetition
   logic [31:0] low_cnt_r;
   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         low_cnt_r <= 32'h0;
      end else begin
         low_cnt_r <= sys_reset_oe_o ? low_cnt_r + 32'h1 : 32'h0;
      end
   end
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);
   sequence s_pg_held;
      (!power_good_strobe_n_i)[*6];
   endsequence
   sequence s_pg_idle;
      (power_good_strobe_n_i && !straps_as_outputs_o)[*4];
   endsequence
   // ====
   // properties
   chk_capture_due: assert property (s_pg_held |-> straps_as_outputs_o)
      else $error("straps not captured after power good");
   chk_no_early: assert property (s_pg_idle |=> !straps_as_outputs_o)
      else $error("straps captured without power good");
   chk_cap_sticky: assert property (straps_as_outputs_o |=> straps_as_outputs_o)
      else $error("capture flag dropped");
   chk_drive_value: assert property ($rose(straps_as_outputs_o) |-> ##2
      drive_current_mode_o == {straps_i.drive_current_strap_hi,
      straps_i.drive_current_strap_lo})
      else $error("drive mode not latched from straps");
   chk_drive_hold: assert property (straps_as_outputs_o &&
      $past(straps_as_outputs_o, 3) |-> $stable(drive_current_mode_o))
      else $error("drive mode moved after capture");
   chk_free_clocks: assert property (free_running_pci_enable_o == 3'h7
      && usb_48m_enable_o)
      else $error("free running or usb clock stopped");
   chk_pd_enter: assert property ((!power_down_in_n_i)[*4] |-> power_down_o)
      else $error("power down not entered");
   chk_pd_leave: assert property (power_down_in_n_i[*4] |-> !power_down_o)
      else $error("power down not left");
   chk_pulse_len: assert property ($fell(sys_reset_oe_o) |->
      low_cnt_r == RESET_PULSE_CYCLES)
      else $error("reset pulse length wrong");
   chk_pulse_max: assert property (low_cnt_r <= RESET_PULSE_CYCLES)
      else $error("reset pulse too long");
   chk_pin_low: assert property (sys_reset_oe_o |-> !sys_reset_n_o)
      else $error("reset pin driven high");
endmodule : slcs_checker

/* testbench/slcs_host_model.sv */
// management host model driving the configuration fields
`timescale 1ns/10ps
module slcs_host_model
   import slcs_pkg::*;
(
   input wire logic host_clk_i,
   output slcs_host_cfg_s host_cfg_o
);
   initial begin
      host_cfg_o = '0;
   end
   // ====
   // one-cycle write; data inverted afterwards so stale data is not reused
   task automatic write16(input logic [7:0] d);
      @(posedge host_clk_i);
      host_cfg_o.cfg16_wdata <= d;
      host_cfg_o.cfg16_wr <= 1'b1;
      @(posedge host_clk_i);
      host_cfg_o.cfg16_wr <= 1'b0;
      host_cfg_o.cfg16_wdata <= ~d;
   endtask : write16
   task automatic set_freq(input logic en, input logic [4:0] sel,
                           input logic safe_en);
      @(posedge host_clk_i);
      host_cfg_o.sw_freq_enable <= en;
      host_cfg_o.sw_freq_select <= sel;
      host_cfg_o.safe_freq_reload_enable <= safe_en;
      host_cfg_o.safe_freq_select <= 5'h03;
   endtask : set_freq
endmodule : slcs_host_model

/* testbench/testbench.sv */
// self-checking bench for the strap latch and clock select block
`timescale 1ns/10ps
module testbench
   import slcs_pkg::*;
;
   localparam int unsigned PULSE = 20;
   logic clk_i, reset_i, host_clk_i, host_reset_i, watchdog_timeout_i;
   logic power_good_strobe_n_i, power_down_in_n_i;
   logic straps_as_outputs_o, shared_out_is_48m_o, super_io_clock_is_48m_o;
   logic usb_48m_enable_o, power_down_o, sys_reset_n_o, sys_reset_oe_o;
   logic [7:0] cfg16_rdata_o;
   logic [5:0] pci_stop_i, pci_enable_o;
   logic [4:0] freq_code_o;
   logic [2:0] free_running_pci_enable_o;
   logic [1:0] drive_current_mode_o;
   slcs_host_cfg_s host_cfg_i;
   slcs_straps_s straps_i;
   int n_errors = 0, num_checks = 0, cycles = 0, i, n;
   slcs_top #(.RESET_PULSE_CYCLES(PULSE)) dut (.*);
   slcs_host_model host (.host_clk_i(host_clk_i), .host_cfg_o(host_cfg_i));
   // ====
   // clocks; link clock offset so the phases never line up
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   initial begin
      host_clk_i = 1'b0;
      #3;
      forever #16 host_clk_i = ~host_clk_i;
   end
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 3000) begin
         n_errors++;
         tally_and_finish();
      end
   end
   // ====
   // helpers
   task automatic wait_clk(input int k);
      repeat (k) @(posedge clk_i);
   endtask : wait_clk
   task automatic check(input string name, input logic [7:0] exp,
                        input logic [7:0] got);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value %s expected %h seen %h", name, exp, got);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : tally_and_finish
   // ====
   // scenarios
   task automatic t_capture();
      check("captured", 8'h0, straps_as_outputs_o);
      check("readback", 8'h40, cfg16_rdata_o);
      host.write16(8'h40);
      wait_clk(1);
      power_good_strobe_n_i <= 1'b0;
      for (i = 0; i < 20 && straps_as_outputs_o !== 1'b1; i++) wait_clk(1);
      wait_clk(30);
      check("freq", 8'h0a, freq_code_o);
      check("drive", 8'h2, drive_current_mode_o);
      check("shared", 8'h1, shared_out_is_48m_o);
      check("super io", 8'h1, super_io_clock_is_48m_o);
      straps_i <= '0;
      power_good_strobe_n_i <= 1'b1;
      wait_clk(8);
      check("freq hold", 8'h0a, freq_code_o);
      check("drive hold", 8'h2, drive_current_mode_o);
   endtask : t_capture
   task automatic t_cfg16();
      logic [7:0] vals [3] = '{8'h40, 8'hbf, 8'hc0};
      foreach (vals[k]) begin
         host.write16(vals[k]);
         wait_clk(30);
         check("shared", {7'h0, ~vals[k][6]}, shared_out_is_48m_o);
         check("super io", {7'h0, vals[k][7]}, super_io_clock_is_48m_o);
         check("readback", vals[k] & 8'hc0, cfg16_rdata_o);
      end
   endtask : t_cfg16
   task automatic t_pins();
      host.set_freq(1'b1, 5'h15, 1'b0);
      wait_clk(1);
      pci_stop_i <= 6'h2a;
      power_down_in_n_i <= 1'b0;
      wait_clk(12);
      check("sw freq", 8'h15, freq_code_o);
      check("pci", 8'h15, pci_enable_o);
      check("free pci", 8'h7, free_running_pci_enable_o);
      check("usb", 8'h1, usb_48m_enable_o);
      check("pd", 8'h1, power_down_o);
      power_down_in_n_i <= 1'b1;
      wait_clk(6);
      check("pd off", 8'h0, power_down_o);
   endtask : t_pins
   task automatic t_watchdog();
      watchdog_timeout_i <= 1'b1;
      n = 0;
      for (i = 0; i < 20 && sys_reset_oe_o !== 1'b1; i++) wait_clk(1);
      check("reset pin", 8'h0, sys_reset_n_o);
      while (sys_reset_oe_o === 1'b1 && n < 100) begin
         n++;
         wait_clk(1);
      end
      check("pulse", PULSE[7:0], n[7:0]);
      check("reload", 8'h0a, freq_code_o);
      // second timeout with safe reload set picks the safe code
      watchdog_timeout_i <= 1'b0;
      host.set_freq(1'b1, 5'h15, 1'b1);
      wait_clk(4);
      watchdog_timeout_i <= 1'b1;
      wait_clk(PULSE + 10);
      check("safe reload", 8'h03, freq_code_o);
   endtask : t_watchdog
   initial begin
      reset_i = 1'b1;
      host_reset_i = 1'b1;
      power_good_strobe_n_i = 1'b1;
      power_down_in_n_i = 1'b1;
      watchdog_timeout_i = 1'b0;
      pci_stop_i = 6'h0;
      // straps valid before power good, as the power source guarantees
      straps_i = {5'h0a, 1'b0, 1'b1, 1'b1, 1'b0};
      wait_clk(4);
      reset_i <= 1'b0;
      host_reset_i <= 1'b0;
      wait_clk(4);
      t_capture();
      t_cfg16();
      t_pins();
      t_watchdog();
      tally_and_finish();
   end
endmodule : testbench
bind slcs_top slcs_checker #(.RESET_PULSE_CYCLES(RESET_PULSE_CYCLES)) chk (.*);
